// file: rtl/sso_defines.svh
/*
  Offsets, opcode patterns, field positions and reset values of the
  set/sleep/subtract execution block.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef SSO_DEFINES_SVH
`define SSO_DEFINES_SVH

`define SSO_ADDR_W 8
`define SSO_REG_INSTR 8'h00
`define SSO_REG_ACC 8'h04
`define SSO_REG_BANK 8'h08
`define SSO_REG_STATUS 8'h0c
`define SSO_REG_MEM_ADDR 8'h10
`define SSO_REG_MEM_DATA 8'h14
`define SSO_REG_WAKE 8'h18

`define SSO_OPC_SET 7'h34
`define SSO_OPC_SUB 6'h15
`define SSO_OPC_SLEEP 16'h0003
`define SSO_BIT_A 8
`define SSO_BIT_D 9
`define SSO_ALL_ONES 8'hff
`define SSO_ACCESS_BANK 4'h0
`define SSO_MEM_WORDS 4096

`define SSO_ST_PD 5
`define SSO_ST_TO 6
`define SSO_ST_BUSY 7
`define SSO_ST_ASLEEP 8
`define SSO_WAKE_WDT 0
`define SSO_WAKE_OTHER 1

`define SSO_RST_TO 1'b1
`define SSO_RST_PD 1'b1
`define SSO_RST_ACC 8'h00
`define SSO_RST_BANK 4'h0

`define SSO_RESP_OKAY 2'h0
`define SSO_RESP_SLVERR 2'h2

`endif

// file: rtl/sso_pkg.sv
/*
  Types of the set/sleep/subtract execution block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sso_pkg;

  typedef enum logic [2:0] {
    SSO_IDLE, SSO_Q1, SSO_Q2, SSO_Q3, SSO_Q4, SSO_SLEEP
  } sso_state_t;

  typedef enum logic [1:0] {
    SSO_OP_NONE, SSO_OP_SET, SSO_OP_SLEEP, SSO_OP_SUB
  } sso_op_t;

  // Same bit order as the low status bits: N OV Z DC C
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } sso_flags_t;

endpackage

// file: rtl/sso_alu.sv
/*
  Subtract-with-borrow arithmetic: acc - operand - not carry.
  Assumes purely combinational use inside the core sequencer.
*/
`timescale 1ns/1ps
module sso_alu (
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  // Result
  output logic [7:0] diff,
  output sso_pkg::sso_flags_t flags
);
  import sso_pkg::*;

  logic [8:0] full;
  logic [4:0] low;

  // Two's complement: add inverted operand plus carry as not-borrow
  always_comb
  begin
    full = {1'b0, acc} + {1'b0, ~operand} + {8'h00, carry_in};
    low = {1'b0, acc[3:0]} + {1'b0, ~operand[3:0]} + {4'h0, carry_in};
    diff = full[7:0];
    flags.c = full[8];
    flags.dc = low[4];
    flags.z = (full[7:0] == 8'h00);
    flags.n = full[7];
    flags.ov = (acc[7] != operand[7]) && (full[7] != acc[7]);
  end

endmodule

// file: rtl/sso_core.sv
/*
  Execution core for the set-all-ones, sleep and subtract-with-borrow
  instructions, with data memory, accumulator, bank pointer, status
  flags and an AXI4-Lite register slave.
  Assumes one clock, AXI4-Lite master with one write and one read
  outstanding, and a watchdog outside that reports wake-up by register.
*/
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
// What this block does
// - Set-all-ones decoded when upper seven bits are 0110100, then a, f.
// - Set-all-ones writes FFh to the addressed register, flags untouched.
// - Bank bit 0 selects the fixed access bank, bank pointer ignored.
// - Bank bit 1 forms the address from the bank pointer register.
// - Sleep sets timeout 1, power-down 0; watchdog wake clears timeout.
// - Subtract computes acc minus register minus not carry, sets flags.
// - Subtract result to acc when d is 0, to register when 1.
`timescale 1ns/1ps
`include "sso_defines.svh"
module sso_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write address and data
  input wire logic [`SSO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`SSO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sso_pkg::*;

  function automatic sso_op_t decode_op(input logic [15:0] w);
    if (w[15:9] == `SSO_OPC_SET)
      decode_op = SSO_OP_SET;
    else if (w[15:10] == `SSO_OPC_SUB)
      decode_op = SSO_OP_SUB;
    else if (w == `SSO_OPC_SLEEP)
      decode_op = SSO_OP_SLEEP;
    else
      decode_op = SSO_OP_NONE;
  endfunction

  function automatic logic [11:0] eff_addr(input logic [15:0] w,
                                           input logic [3:0] bp);
    if (w[`SSO_BIT_A])
      eff_addr = {bp, w[7:0]};
    else
      eff_addr = {`SSO_ACCESS_BANK, w[7:0]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction

  logic [7:0] data_mem [0:`SSO_MEM_WORDS-1];
  sso_state_t state;
  sso_op_t op;
  logic [15:0] instr_word;
  logic [11:0] ea;
  logic [7:0] operand;
  logic [7:0] result;
  sso_flags_t result_flags;
  logic [7:0] acc;
  logic [3:0] bank_pointer_register;
  sso_flags_t flags;
  logic timeout_flag;
  logic power_down_flag;
  logic [11:0] mem_addr;
  logic [7:0] alu_diff;
  sso_flags_t alu_flags;

  logic aw_held, w_held;
  logic [`SSO_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_hs, w_hs, ar_hs, do_write, core_quiet, wr_ok;
  logic next_aw_held, next_w_held;
  logic [`SSO_ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wake_wdt, wake_other, wr_instr;
  logic [31:0] instr_mg, acc_mg, stat_mg, bank_mg, addr_mg;

  sso_alu u_alu (
    .acc(acc),
    .operand(operand),
    .carry_in(flags.c),
    .diff(alu_diff),
    .flags(alu_flags)
  );

  // Register writes wait while an instruction is in flight
  assign core_quiet = (state == SSO_IDLE) || (state == SSO_SLEEP);
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    wa = aw_held ? aw_addr_q : s_axi_awaddr;
    wd = w_held ? w_data_q : s_axi_wdata;
    ws = w_held ? w_strb_q : s_axi_wstrb;
    do_write = (aw_held || aw_hs) && (w_held || w_hs) && !s_axi_bvalid
               && core_quiet;
    next_aw_held = (aw_held || aw_hs) && !do_write;
    next_w_held = (w_held || w_hs) && !do_write;
    wr_ok = (wa <= `SSO_REG_WAKE) && (wa[1:0] == 2'b00);
  end

  assign wr_instr = do_write && (wa == `SSO_REG_INSTR) && (ws[1:0] != 2'b00)
                    && (state == SSO_IDLE);
  assign wake_wdt = do_write && (wa == `SSO_REG_WAKE) && ws[0]
                    && wd[`SSO_WAKE_WDT] && (state == SSO_SLEEP);
  assign wake_other = do_write && (wa == `SSO_REG_WAKE) && ws[0]
                      && wd[`SSO_WAKE_OTHER] && (state == SSO_SLEEP);

  // Lane merges as nets, since a call's result cannot be sliced
  assign instr_mg = merge({16'h0, instr_word}, wd, ws);
  assign acc_mg = merge({24'h0, acc}, wd, ws);
  assign stat_mg = merge({27'h0, flags}, wd, ws);
  assign bank_mg = merge({28'h0, bank_pointer_register}, wd, ws);
  assign addr_mg = merge({20'h0, mem_addr}, wd, ws);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSO_RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_hs)
        aw_addr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SSO_RESP_OKAY : `SSO_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SSO_REG_INSTR: rd_data = {16'h0, instr_word};
      `SSO_REG_ACC: rd_data = {24'h0, acc};
      `SSO_REG_BANK: rd_data = {28'h0, bank_pointer_register};
      `SSO_REG_STATUS: rd_data = {23'h0, state == SSO_SLEEP, !core_quiet,
                                  timeout_flag, power_down_flag, flags};
      `SSO_REG_MEM_ADDR: rd_data = {20'h0, mem_addr};
      `SSO_REG_MEM_DATA: rd_data = {24'h0, data_mem[mem_addr]};
      `SSO_REG_WAKE: rd_data = 32'h0;
      default:
      begin
        rd_data = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SSO_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? `SSO_RESP_OKAY : `SSO_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Quarter-cycle sequencer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= SSO_IDLE;
    else
      case (state)
        SSO_IDLE: if (wr_instr) state <= SSO_Q1;
        SSO_Q1: state <= SSO_Q2;
        SSO_Q2: state <= SSO_Q3;
        SSO_Q3: state <= SSO_Q4;
        SSO_Q4: state <= (op == SSO_OP_SLEEP) ? SSO_SLEEP : SSO_IDLE;
        SSO_SLEEP: if (wake_wdt || wake_other) state <= SSO_IDLE;
        default: state <= SSO_IDLE;
      endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      instr_word <= 16'h0000;
      op <= SSO_OP_NONE;
      ea <= 12'h000;
      operand <= 8'h00;
      result <= 8'h00;
      result_flags <= '0;
    end
    else
    begin
      if (wr_instr)
        instr_word <= instr_mg[15:0];
      if (state == SSO_Q1)
      begin
        op <= decode_op(instr_word);
        ea <= eff_addr(instr_word, bank_pointer_register);
      end
      // Sleep performs no read in the second quarter
      if (state == SSO_Q2 && op != SSO_OP_SLEEP)
        operand <= data_mem[ea];
      if (state == SSO_Q3)
      begin
        result <= (op == SSO_OP_SET) ? `SSO_ALL_ONES : alu_diff;
        result_flags <= alu_flags;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      acc <= `SSO_RST_ACC;
    else if (state == SSO_Q4 && op == SSO_OP_SUB && !instr_word[`SSO_BIT_D])
      acc <= result;
    else if (do_write && wa == `SSO_REG_ACC)
      acc <= acc_mg[7:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags <= '0;
      bank_pointer_register <= `SSO_RST_BANK;
      mem_addr <= 12'h000;
    end
    else
    begin
      if (state == SSO_Q4 && op == SSO_OP_SUB)
        flags <= result_flags;
      else if (do_write && wa == `SSO_REG_STATUS)
        flags <= sso_flags_t'(stat_mg[4:0]);
      if (do_write && wa == `SSO_REG_BANK)
        bank_pointer_register <= bank_mg[3:0];
      if (do_write && wa == `SSO_REG_MEM_ADDR)
        mem_addr <= addr_mg[11:0];
    end
  end

  // Array left without reset so it maps onto plain RAM
  always_ff @(posedge clk)
  begin
    if (state == SSO_Q4 && (op == SSO_OP_SET
        || (op == SSO_OP_SUB && instr_word[`SSO_BIT_D])))
      data_mem[ea] <= result;
    else if (do_write && wa == `SSO_REG_MEM_DATA && ws[0])
      data_mem[mem_addr] <= wd[7:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timeout_flag <= `SSO_RST_TO;
      power_down_flag <= `SSO_RST_PD;
    end
    else if (state == SSO_Q4 && op == SSO_OP_SLEEP)
    begin
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b0;
    end
    else if (wake_wdt)
      timeout_flag <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  set_decode_a: assert property (
    state == SSO_Q1 && instr_word[15:9] == `SSO_OPC_SET |=> op == SSO_OP_SET)
    else $error("set-all-ones word not decoded");
  set_write_a: assert property (
    state == SSO_Q4 && op == SSO_OP_SET |=> data_mem[ea] == 8'hff
      && $stable(flags) && $stable(acc))
    else $error("set-all-ones did not write ones or touched flags");
  access_bank_a: assert property (
    state == SSO_Q1 && !instr_word[`SSO_BIT_A] |=> ea[11:8] == 4'h0
      && ea[7:0] == $past(instr_word[7:0]))
    else $error("access bank address wrong");
  bank_select_a: assert property (
    state == SSO_Q1 && instr_word[`SSO_BIT_A] |=>
      ea == {$past(bank_pointer_register), $past(instr_word[7:0])})
    else $error("banked address wrong");
  sleep_flags_a: assert property (
    state == SSO_Q4 && op == SSO_OP_SLEEP |=> timeout_flag
      && !power_down_flag && state == SSO_SLEEP)
    else $error("sleep flags wrong");
  wdt_wake_a: assert property (
    wake_wdt |=> !timeout_flag && state == SSO_IDLE)
    else $error("watchdog wake did not clear timeout");
  sub_acc_a: assert property (
    state == SSO_Q2 && op == SSO_OP_SUB && !instr_word[`SSO_BIT_D] |=>
      ##2 acc == 8'($past(acc, 3) - $past(data_mem[ea], 3)
      - {7'h0, !$past(flags.c, 3)}))
    else $error("subtract into acc wrong");
  sub_dest_a: assert property (
    state == SSO_Q4 && op == SSO_OP_SUB && instr_word[`SSO_BIT_D] |=>
      data_mem[ea] == $past(result) && $stable(acc))
    else $error("subtract into register wrong");
  one_cycle_a: assert property (
    state == SSO_Q1 |=> state == SSO_Q2 ##1 state == SSO_Q3
      ##1 state == SSO_Q4 ##1 (state == SSO_IDLE || state == SSO_SLEEP))
    else $error("instruction not four quarters");

  set_run_c: cover property (state == SSO_Q4 && op == SSO_OP_SET);
  sleep_run_c: cover property (state == SSO_Q4 && op == SSO_OP_SLEEP);
  sub_acc_c: cover property (state == SSO_Q4 && op == SSO_OP_SUB
    && !instr_word[`SSO_BIT_D]);
  wdt_wake_c: cover property (wake_wdt);

endmodule

// file: tb/set_sleep_subtract_ops_test.sv
/*
  Self-checking bench of the set/sleep/subtract core, driven over
  AXI4-Lite with expected answers noted in queues.
  Assumes sso_defines.svh on the include path and one 250 MHz clock.
*/
`timescale 1ns/1ps
`include "sso_defines.svh"
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end \
  end
module set_sleep_subtract_ops_test;
  import sso_pkg::*;
  typedef struct {string nm; logic [33:0] v;} sso_note_t;
  logic clk, sys_rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int err_total = 0;
  int num_checks = 0;
  logic to_f, pd_f;
  sso_note_t rq[$];
  sso_note_t note;
  logic [1:0] bq[$];
  logic [1:0] be;

  sso_core DUT (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Sampled before the edge's updates land, so values are pre-edge
  always @(posedge clk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      note = rq.pop_front();
      `CHK(note.nm, note.v, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
    begin
      be = bq.pop_front();
      `CHK("bresp", be, s_axi_bresp)
    end
  end

  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 400)
    begin
      `CHK("timeout", 1'b0, 1'b1)
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `SSO_RESP_OKAY);
    int n;
    logic aw_p;
    logic w_p;
    n = 0;
    aw_p = 1;
    w_p = 1;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw_p || w_p)
    begin
      step(n);
      if (aw_p && s_axi_awready === 1'b1)
      begin
        aw_p = 0;
        s_axi_awvalid <= 0;
      end
      if (w_p && s_axi_wready === 1'b1)
      begin
        w_p = 0;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      step(n);
    s_axi_bready <= 0;
    // Spare edge so the next transfer never re-drives in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input string nm, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    rq.push_back('{nm, {er, ex}});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do step(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do step(n); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] st(input logic [4:0] fl,
                                     input logic bz, input logic sl);
    return {23'h0, sl, bz, to_f, pd_f, fl};
  endfunction

  task automatic poke(input logic [11:0] a, input logic [7:0] v);
    wr(`SSO_REG_MEM_ADDR, {20'h0, a});
    wr(`SSO_REG_MEM_DATA, {24'h0, v});
  endtask

  task automatic peek(input logic [11:0] a, input logic [7:0] v);
    wr(`SSO_REG_MEM_ADDR, {20'h0, a});
    rd(`SSO_REG_MEM_DATA, {24'h0, v}, "mem");
  endtask

  // Four execution cycles, the edge that lands the result and one spare edge
  task automatic run(input logic [15:0] op);
    wr(`SSO_REG_INSTR, {16'h0, op});
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [12:0] sub_ref(input logic [7:0] w,
                                          input logic [7:0] f,
                                          input logic c);
    logic [8:0] r;
    logic [4:0] lo;
    logic ov;
    r = {1'b0, w} - {1'b0, f} - {8'h0, ~c};
    lo = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~c};
    ov = (w[7] != f[7]) && (r[7] != w[7]);
    return {r[7], ov, r[7:0] == 8'h0, ~lo[4], ~r[8], r[7:0]};
  endfunction

  initial
  begin
    logic [7:0] w, m, f;
    logic [3:0] bk;
    logic c, d, a;
    logic [4:0] fl;
    logic [11:0] ad;
    logic [12:0] ex;
    sys_rst = 1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    to_f = 1;
    pd_f = 1;
    void'($urandom(6610));
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rd(`SSO_REG_STATUS, st(5'h0, 0, 0), "status");
    rd(`SSO_REG_ACC, 32'h0, "acc");
    rd(8'h1c, 32'h0, "unmapped", `SSO_RESP_SLVERR);
    rd(8'h05, 32'h0, "unaligned", `SSO_RESP_SLVERR);
    wr(8'h1c, 32'h5, `SSO_RESP_SLVERR);
    wr(`SSO_REG_BANK, 32'h3);
    poke(12'h042, 8'h5a);
    poke(12'h342, 8'h11);
    wr(`SSO_REG_STATUS, 32'h15);
    run(16'h6a42);
    peek(12'h042, 8'h5a);
    peek(12'h342, 8'h11);
    wr(`SSO_REG_INSTR, 32'h6842);
    rd(`SSO_REG_STATUS, st(5'h15, 1, 0), "busy");
    repeat (6) @(posedge clk);
    peek(12'h042, `SSO_ALL_ONES);
    peek(12'h342, 8'h11);
    rd(`SSO_REG_STATUS, st(5'h15, 0, 0), "flags");
    run(16'h6942);
    peek(12'h342, `SSO_ALL_ONES);
    repeat (16)
    begin
      w = 8'($urandom);
      m = 8'($urandom);
      f = 8'($urandom);
      bk = 4'($urandom);
      fl = 5'($urandom);
      {c, d, a} = 3'($urandom);
      ad = a ? {bk, f} : {4'h0, f};
      ex = sub_ref(w, m, c);
      wr(`SSO_REG_BANK, {28'h0, bk});
      poke(ad, m);
      wr(`SSO_REG_ACC, {24'h0, w});
      wr(`SSO_REG_STATUS, {27'h0, fl[4:1], c});
      run({`SSO_OPC_SUB, d, a, f});
      rd(`SSO_REG_ACC, {24'h0, d ? w : ex[7:0]}, "acc");
      peek(ad, d ? ex[7:0] : m);
      rd(`SSO_REG_STATUS, st(ex[12:8], 0, 0), "flags");
    end
    run(`SSO_OPC_SLEEP);
    to_f = 1;
    pd_f = 0;
    rd(`SSO_REG_STATUS, st(ex[12:8], 0, 1), "sleep");
    poke(12'h042, 8'h22);
    run(16'h6842);
    peek(12'h042, 8'h22);
    wr(`SSO_REG_WAKE, 32'h1);
    repeat (2) @(posedge clk);
    to_f = 0;
    rd(`SSO_REG_STATUS, st(ex[12:8], 0, 0), "wdt wake");
    run(`SSO_OPC_SLEEP);
    to_f = 1;
    rd(`SSO_REG_STATUS, st(ex[12:8], 0, 1), "sleep");
    wr(`SSO_REG_WAKE, 32'h2);
    repeat (2) @(posedge clk);
    rd(`SSO_REG_STATUS, st(ex[12:8], 0, 0), "wake");
    finish_test();
  end
endmodule
